/* hw/swc_consts.vh */
// Register offsets, field positions, reset values and timing counts of the sleep and wake controller.
`ifndef SWC_CONSTS_VH
`define SWC_CONSTS_VH

// Register byte offsets on the APB.
`define SWC_OFF_CTRL 8'h00
`define SWC_OFF_INTERVAL 8'h04
`define SWC_OFF_EVLEN 8'h08
`define SWC_OFF_STATUS 8'h0C
`define SWC_OFF_IRQ_STAT 8'h10
`define SWC_OFF_IRQ_EN 8'h14
`define SWC_OFF_IRQ_CLR 8'h18

// Control register fields.
`define SWC_CTRL_SLEEP_EN 0
`define SWC_CTRL_WAKE_POL 1
`define SWC_CTRL_HOST_POL 2
`define SWC_CTRL_USB_MODE 3
`define SWC_CTRL_RADIO_OFF_EN 4
`define SWC_CTRL_SESSION_EN 5
`define SWC_CTRL_ALARM_EN 6
`define SWC_CTRL_HOST_ATTN 7
`define SWC_CTRL_W 8
`define SWC_CTRL_RESET 8'h00

// Interrupt status bits.
`define SWC_IRQ_HOST_WAKE 0
`define SWC_IRQ_EVENT 1
`define SWC_IRQ_SLEEP 2
`define SWC_IRQ_ALARM 3
`define SWC_IRQ_RESUME 4
`define SWC_IRQ_W 5

// Reset values of the timing registers, in low-power ticks and core cycles.
`define SWC_INTERVAL_RESET 16'h0100
`define SWC_EVLEN_RESET 16'h0040

`endif

/* hw/swc_sync.v */
// Two flip-flop synchroniser for a group of level inputs.
`timescale 1ns/100ps
module swc_sync #(
   parameter W = 1
) (
   // Clock and reset.
   input wire clk,
   input wire rst_n,
   // Asynchronous levels in, synchronised levels out.
   input wire [W-1:0] d,
   output reg [W-1:0] q
);
   reg [W-1:0] meta_q; // First stage, read only by the second stage.

   // Two stages in series; the first is never looked at by any other logic.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= {W{1'b0}};
         q <= {W{1'b0}};
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule // swc_sync

/* hw/swc_lpo_timer.v */
// Reloading interval timer counted in low-power oscillator ticks.
`timescale 1ns/100ps
module swc_lpo_timer #(
   parameter CNT_W = 16
) (
   // Clock and reset.
   input wire clk,
   input wire rst_n,
   // Control.
   input wire enable,
   input wire tick,
   input wire [CNT_W-1:0] interval,
   // One-cycle pulse when the interval has run out.
   output reg expire
);
   reg [CNT_W-1:0] cnt_q; // Ticks left until expiry.

   // Count down on each tick and reload at the end; a disabled timer restarts from the full interval.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= {CNT_W{1'b0}};
         expire <= 1'b0;
      end else begin
         expire <= 1'b0;
         if (!enable) begin
            cnt_q <= interval;
         end else if (tick) begin
            if (cnt_q <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
               cnt_q <= interval;
               expire <= 1'b1;
            end else begin
               cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule // swc_lpo_timer

/* hw/swc_top.v */
// Sleep and wake controller of the transceiver core with its APB register file.
`timescale 1ns/100ps
`include "swc_consts.vh"
module swc_top #(
   parameter CNT_W = 16
) (
   // Clock and reset.
   input wire SYS_CLK,
   input wire RSTN,
   // APB slave.
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [7:0] PADDR,
   input wire [31:0] PWDATA,
   output reg [31:0] PRDATA,
   output reg PREADY,
   output reg PSLVERR,
   // Wake pins and oscillator.
   input wire DEVICE_WAKE_IN,
   input wire LOW_POWER_OSC,
   output reg HOST_WAKE_OUT,
   output reg REFCLK_REQUEST_OUT,
   // USB link power signalling.
   input wire USB_SUSPEND,
   input wire USB_RESUME,
   output reg USB_REMOTE_WAKE,
   // Baseband packet activity and power controls.
   input wire PKT_TX_ACTIVE,
   input wire PKT_RX_ACTIVE,
   output reg RF_TX_EN,
   output reg RF_RX_EN,
   output reg CORE_CLK_EN,
   output reg TRANSPORT_IDLE,
   output reg RADIO_OFF,
   // Interrupt.
   output reg IRQ
);

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations.
   localparam [1:0] ST_AWAKE = 2'h0; // Core running, transports live.
   localparam [1:0] ST_SLEEP = 2'h1; // Core clocks gated, interval timer still counting.
   localparam [1:0] ST_EVENT = 2'h2; // Up for one scheduled event, transports still idle.
   reg [`SWC_CTRL_W-1:0] ctrl_q; // Control register.
   reg [CNT_W-1:0] interval_q; // Wake interval in oscillator ticks.
   reg [CNT_W-1:0] evlen_q; // Length of one scheduled event in core cycles.
   reg [`SWC_IRQ_W-1:0] irq_stat_q; // Sticky event bits.
   reg [`SWC_IRQ_W-1:0] irq_en_q; // Interrupt enables.
   reg [`SWC_IRQ_W-1:0] irq_set; // Events of this cycle.
   reg [1:0] state_q; // Controller state.
   reg [1:0] state_d; // Next controller state.
   reg [CNT_W-1:0] ev_cnt_q; // Core cycles left in the running event.
   reg osc_prev_q; // Oscillator level of the previous cycle for edge detection.
   reg resume_prev_q; // Resume level of the previous cycle.
   wire [2:0] sync_q; // Synchronised wake, oscillator and suspend levels.
   wire wake_lvl; // Synchronised wake pin level.
   wire osc_lvl; // Synchronised oscillator level.
   wire suspend_lvl; // Synchronised suspend level.
   wire osc_tick; // One pulse per oscillator rising edge.
   wire timer_expire; // Interval timer ran out.
   wire timer_en; // Interval timer counts.
   wire pin_wake; // Wake pin in its asserted state.
   wire wake_req; // Host wants the device awake.
   wire usb_mode; // USB link power management in use.
   wire ev_busy; // A scheduled event is running.
   wire sleep_ok; // All sleep criteria met.
   wire host_need; // Device needs the host.
   wire apb_acc; // Access phase of a transfer.
   wire wr_en; // Register write takes effect.

   // Apply the selected polarity to a pin level; pol high means active high.
   function act_level;
      input lvl;
      input pol;
      begin
         act_level = pol ? lvl : ~lvl;
      end
   endfunction

   // Tell whether an address hits a mapped register.
   function addr_hit;
      input [7:0] a;
      begin
         addr_hit = (a == `SWC_OFF_CTRL) || (a == `SWC_OFF_INTERVAL) || (a == `SWC_OFF_EVLEN) ||
            (a == `SWC_OFF_STATUS) || (a == `SWC_OFF_IRQ_STAT) || (a == `SWC_OFF_IRQ_EN) ||
            (a == `SWC_OFF_IRQ_CLR);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Input synchronisation.
   // Wake pin, oscillator and suspend level all pass two flip-flops before use.
   swc_sync #(
      .W(3)
   ) u_sync (
      .clk(SYS_CLK),
      .rst_n(RSTN),
      .d({USB_SUSPEND, LOW_POWER_OSC, DEVICE_WAKE_IN}),
      .q(sync_q)
   );

   assign wake_lvl = sync_q[0];
   assign osc_lvl = sync_q[1];
   assign suspend_lvl = sync_q[2];

   // Remember the previous oscillator and resume levels for edge detection.
   always @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         osc_prev_q <= 1'b0;
         resume_prev_q <= 1'b0;
      end else begin
         osc_prev_q <= osc_lvl;
         resume_prev_q <= USB_RESUME;
      end
   end

   assign osc_tick = osc_lvl & ~osc_prev_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Wake decision.
   assign usb_mode = ctrl_q[`SWC_CTRL_USB_MODE];
   assign pin_wake = act_level(wake_lvl, ctrl_q[`SWC_CTRL_WAKE_POL]);
   // In USB mode the link suspend state stands in for the pin; the pin then only steers radio off.
   assign wake_req = usb_mode ? ~suspend_lvl : pin_wake;
   assign ev_busy = (ev_cnt_q != {CNT_W{1'b0}});
   assign host_need = ctrl_q[`SWC_CTRL_HOST_ATTN] | IRQ;
   // Removing the wake request is itself the request to sleep once sleep is enabled.
   assign sleep_ok = ctrl_q[`SWC_CTRL_SLEEP_EN] & ~wake_req & ~host_need & ~ev_busy;

   ////////////////////////////////////////////////////////////////////////////////
   // Interval timer on the low-power oscillator.
   assign timer_en = ctrl_q[`SWC_CTRL_SESSION_EN] | ctrl_q[`SWC_CTRL_ALARM_EN];

   // The timer keeps counting oscillator ticks through sleep, so sessions keep their schedule.
   swc_lpo_timer #(
      .CNT_W(CNT_W)
   ) u_timer (
      .clk(SYS_CLK),
      .rst_n(RSTN),
      .enable(timer_en),
      .tick(osc_tick),
      .interval(interval_q),
      .expire(timer_expire)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Sleep state machine.
   // Choose the next state from the wake request, the timer and the event counter.
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_AWAKE: begin
            if (sleep_ok) begin
               state_d = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (wake_req) begin
               state_d = ST_AWAKE;
            end else if (timer_expire && ctrl_q[`SWC_CTRL_SESSION_EN]) begin
               state_d = ST_EVENT;
            end else if (timer_expire && ctrl_q[`SWC_CTRL_ALARM_EN]) begin
               state_d = ST_AWAKE;
            end
         end
         ST_EVENT: begin
            // A host wake during the event keeps the device up between later events.
            if (wake_req) begin
               state_d = ST_AWAKE;
            end else if (!ev_busy) begin
               state_d = ST_SLEEP;
            end
         end
         default: begin
            state_d = ST_AWAKE;
         end
      endcase
   end

   // Advance the state; the event counter is loaded at every scheduled event, asleep or awake.
   always @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         state_q <= ST_AWAKE;
         ev_cnt_q <= {CNT_W{1'b0}};
      end else begin
         state_q <= state_d;
         if (timer_expire && ctrl_q[`SWC_CTRL_SESSION_EN]) begin
            ev_cnt_q <= evlen_q;
         end else if (ev_busy) begin
            ev_cnt_q <= ev_cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Power control outputs.
   // The clock, reference clock, transport and RF outputs are registered from the next state so they switch with it.
   always @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         CORE_CLK_EN <= 1'b1;
         REFCLK_REQUEST_OUT <= 1'b1;
         TRANSPORT_IDLE <= 1'b0;
         RADIO_OFF <= 1'b0;
         RF_TX_EN <= 1'b0;
         RF_RX_EN <= 1'b0;
         HOST_WAKE_OUT <= 1'b1;
         USB_REMOTE_WAKE <= 1'b0;
      end else begin
         CORE_CLK_EN <= (state_d != ST_SLEEP);
         REFCLK_REQUEST_OUT <= (state_d != ST_SLEEP);
         TRANSPORT_IDLE <= (state_d != ST_AWAKE);
         RADIO_OFF <= usb_mode & ctrl_q[`SWC_CTRL_RADIO_OFF_EN] & pin_wake;
         // The RF paths switch on only while a packet is actually moving.
         RF_TX_EN <= PKT_TX_ACTIVE & (state_d != ST_SLEEP) & ~RADIO_OFF;
         RF_RX_EN <= PKT_RX_ACTIVE & (state_d != ST_SLEEP) & ~RADIO_OFF;
         // The pin is held inactive in USB mode; remote wake signals the host instead.
         HOST_WAKE_OUT <= act_level(host_need & ~usb_mode, ctrl_q[`SWC_CTRL_HOST_POL]);
         USB_REMOTE_WAKE <= usb_mode & suspend_lvl & host_need;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt events.
   // Collect the events of this cycle.
   always @* begin
      irq_set = {`SWC_IRQ_W{1'b0}};
      irq_set[`SWC_IRQ_HOST_WAKE] = (state_q != ST_AWAKE) && (state_d == ST_AWAKE) && wake_req;
      irq_set[`SWC_IRQ_EVENT] = timer_expire & ctrl_q[`SWC_CTRL_SESSION_EN];
      irq_set[`SWC_IRQ_SLEEP] = (state_q != ST_SLEEP) && (state_d == ST_SLEEP);
      irq_set[`SWC_IRQ_ALARM] = timer_expire & ctrl_q[`SWC_CTRL_ALARM_EN];
      irq_set[`SWC_IRQ_RESUME] = usb_mode & USB_RESUME & ~resume_prev_q;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // APB register file.
   assign apb_acc = PSEL & PENABLE;
   assign wr_en = apb_acc & PREADY & PWRITE & ~PSLVERR;

   // Software registers; a new event wins over a clear of the same status bit.
   always @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         ctrl_q <= `SWC_CTRL_RESET;
         interval_q <= `SWC_INTERVAL_RESET;
         evlen_q <= `SWC_EVLEN_RESET;
         irq_en_q <= {`SWC_IRQ_W{1'b0}};
         irq_stat_q <= {`SWC_IRQ_W{1'b0}};
      end else begin
         if (wr_en && (PADDR == `SWC_OFF_CTRL)) begin
            ctrl_q <= PWDATA[`SWC_CTRL_W-1:0];
         end
         if (wr_en && (PADDR == `SWC_OFF_INTERVAL)) begin
            interval_q <= PWDATA[CNT_W-1:0];
         end
         if (wr_en && (PADDR == `SWC_OFF_EVLEN)) begin
            evlen_q <= PWDATA[CNT_W-1:0];
         end
         if (wr_en && (PADDR == `SWC_OFF_IRQ_EN)) begin
            irq_en_q <= PWDATA[`SWC_IRQ_W-1:0];
         end
         if (wr_en && (PADDR == `SWC_OFF_IRQ_CLR)) begin
            irq_stat_q <= (irq_stat_q & ~PWDATA[`SWC_IRQ_W-1:0]) | irq_set;
         end else begin
            irq_stat_q <= irq_stat_q | irq_set;
         end
      end
   end

   // One wait state: ready rises in the second access cycle with read data and error.
   always @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA <= 32'h00000000;
      end else begin
         PREADY <= apb_acc & ~PREADY;
         PSLVERR <= apb_acc & ~PREADY & ~addr_hit(PADDR);
         PRDATA <= 32'h00000000;
         if (apb_acc && !PREADY && !PWRITE) begin
            case (PADDR)
               `SWC_OFF_CTRL: begin
                  PRDATA <= {{(32-`SWC_CTRL_W){1'b0}}, ctrl_q};
               end
               `SWC_OFF_INTERVAL: begin
                  PRDATA <= {{(32-CNT_W){1'b0}}, interval_q};
               end
               `SWC_OFF_EVLEN: begin
                  PRDATA <= {{(32-CNT_W){1'b0}}, evlen_q};
               end
               `SWC_OFF_STATUS: begin
                  PRDATA <= {24'h000000, RADIO_OFF, ev_busy, suspend_lvl, wake_req, pin_wake, 1'b0, state_q};
               end
               `SWC_OFF_IRQ_STAT: begin
                  PRDATA <= {{(32-`SWC_IRQ_W){1'b0}}, irq_stat_q};
               end
               `SWC_OFF_IRQ_EN: begin
                  PRDATA <= {{(32-`SWC_IRQ_W){1'b0}}, irq_en_q};
               end
               default: begin
                  PRDATA <= 32'h00000000;
               end
            endcase
         end
      end
   end

   // Level interrupt while any enabled status bit is set.
   always @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |(irq_stat_q & irq_en_q);
      end
   end
endmodule // swc_top

/* tb/swc_chk.sv */
// Port checker of the sleep and wake controller.
`timescale 1ns/100ps
module swc_chk (
   // Clock and reset.
   input wire SYS_CLK,
   input wire RSTN,
   // APB.
   input wire PSEL,
   input wire PENABLE,
   input wire [31:0] PRDATA,
   input wire PREADY,
   input wire PSLVERR,
   // Power pins.
   input wire USB_SUSPEND,
   input wire PKT_TX_ACTIVE,
   input wire RF_TX_EN,
   input wire CORE_CLK_EN,
   input wire REFCLK_REQUEST_OUT,
   input wire TRANSPORT_IDLE,
   input wire RADIO_OFF,
   input wire USB_REMOTE_WAKE
);
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!RSTN);
   // The slave answers with exactly one wait state.
   apb_wait_a: assert property (PSEL && !PENABLE |=> !PREADY ##1 PREADY)
      else $error("ready timing wrong");
   ready_pulse_a: assert property (PREADY |=> !PREADY)
      else $error("ready held");
   ready_access_a: assert property (!(PSEL && PENABLE) |-> !PREADY)
      else $error("ready outside access");
   err_ready_a: assert property (PSLVERR |-> PREADY)
      else $error("error without ready");
   rdata_idle_a: assert property (!PREADY |-> PRDATA == 32'h0)
      else $error("read data outside answer");
   // The reference clock is wanted exactly while the core clock runs.
   clkreq_core_a: assert property (REFCLK_REQUEST_OUT == CORE_CLK_EN)
      else $error("clock request mismatch");
   sleep_idle_a: assert property (!CORE_CLK_EN |-> TRANSPORT_IDLE)
      else $error("transport busy asleep");
   rf_cause_a: assert property (RF_TX_EN |-> $past(PKT_TX_ACTIVE) && !$past(RADIO_OFF))
      else $error("rf on without packet");
   rf_asleep_a: assert property (!CORE_CLK_EN && !$past(CORE_CLK_EN) |-> !RF_TX_EN)
      else $error("rf on asleep");
   remote_wake_a: assert property (USB_REMOTE_WAKE |-> $past(USB_SUSPEND, 3))
      else $error("remote wake without suspend");
   // Main scenarios.
   sleep_c: cover property ($fell(CORE_CLK_EN));
   err_c: cover property (PSLVERR);
   remote_c: cover property (USB_REMOTE_WAKE);
   radio_c: cover property (RADIO_OFF && PKT_TX_ACTIVE);
endmodule // swc_chk
bind swc_top swc_chk u_chk (.SYS_CLK, .RSTN, .PSEL, .PENABLE, .PRDATA, .PREADY, .PSLVERR, .USB_SUSPEND,
   .PKT_TX_ACTIVE, .RF_TX_EN, .CORE_CLK_EN, .REFCLK_REQUEST_OUT, .TRANSPORT_IDLE, .RADIO_OFF, .USB_REMOTE_WAKE);

/* tb/swc_host_model.sv */
// Host processor model on the wake pins.
`timescale 1ns/100ps
module swc_host_model (
   // Clock and reset.
   input wire clk,
   input wire rst_n,
   // Bench requests and polarities.
   input wire need_dev,
   input wire wake_pol,
   input wire host_pol,
   // Wake pins.
   output reg dev_wake,
   input wire host_wake,
   // Host power state.
   output reg host_awake
);
   // Pin levels follow the need, in the chosen polarity.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dev_wake <= 1'b1;
         host_awake <= 1'b1;
      end else begin
         dev_wake <= ~(need_dev ^ wake_pol);
         host_awake <= (host_wake == host_pol) | need_dev;
      end
   end
endmodule // swc_host_model

/* tb/swc_tb.sv */
// Self-checking bench of the sleep and wake controller.
`timescale 1ns/100ps
module tb;
   typedef struct packed {logic [32:0] e; logic [32:0] m;} swc_note_t;
   logic SYS_CLK = 1'b0, RSTN = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
   logic [7:0] PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0, r;
   logic LOW_POWER_OSC = 1'b0, USB_SUSPEND = 1'b0, USB_RESUME = 1'b0;
   logic PKT_TX_ACTIVE = 1'b0, PKT_RX_ACTIVE = 1'b0, need = 1'b1, wpol = 1'b0, hpol = 1'b0, rx_q = 1'b0;
   logic [2:0] osc_q = 3'h0;
   wire [31:0] PRDATA;
   wire PREADY, PSLVERR, DEVICE_WAKE_IN, HOST_WAKE_OUT, REFCLK_REQUEST_OUT, USB_REMOTE_WAKE, host_awake;
   wire RF_TX_EN, RF_RX_EN, CORE_CLK_EN, TRANSPORT_IDLE, RADIO_OFF, IRQ;
   wire [5:0] obs = {host_awake, HOST_WAKE_OUT, IRQ, USB_REMOTE_WAKE, RADIO_OFF, CORE_CLK_EN};
   swc_note_t q[$];
   swc_note_t nt;
   int n_fail = 0, comparisons = 0, k;
   swc_top #(.CNT_W(16)) uut (.SYS_CLK, .RSTN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
      .PSLVERR, .DEVICE_WAKE_IN, .LOW_POWER_OSC, .HOST_WAKE_OUT, .REFCLK_REQUEST_OUT, .USB_SUSPEND,
      .USB_RESUME, .USB_REMOTE_WAKE, .PKT_TX_ACTIVE, .PKT_RX_ACTIVE, .RF_TX_EN, .RF_RX_EN, .CORE_CLK_EN,
      .TRANSPORT_IDLE, .RADIO_OFF, .IRQ);
   swc_host_model host (.clk(SYS_CLK), .rst_n(RSTN), .need_dev(need), .wake_pol(wpol), .host_pol(hpol),
      .dev_wake(DEVICE_WAKE_IN), .host_wake(HOST_WAKE_OUT), .host_awake(host_awake));
   always #4 SYS_CLK = ~SYS_CLK;
   // Slow oscillator of eight clocks and random receive activity.
   always @(posedge SYS_CLK) begin
      osc_q <= osc_q + 3'h1;
      LOW_POWER_OSC <= osc_q[2];
      PKT_RX_ACTIVE <= $urandom;
   end
   task automatic wrap_up;
      $display("comparisons %0d failures %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp_pin(input logic got, input logic exp);
      cmp({32'h0, got}, {32'h0, exp});
   endtask
   // One APB transfer; its expected answer goes to the queue.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e,
      input logic [32:0] m);
      int n;
      n = 0;
      q.push_back('{e & m, m});
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge SYS_CLK);
      PENABLE <= 1'b1;
      @(posedge SYS_CLK);
      while (PREADY !== 1'b1) begin
         n++;
         if (n > 20) begin
            n_fail++;
            wrap_up();
         end
         @(posedge SYS_CLK);
      end
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge SYS_CLK);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 33'h0, {33{1'b1}});
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      apb(1'b0, a, 32'h0, {1'b0, e}, {1'b1, m});
   endtask
   // Bounded wait for one observed pin to reach a level.
   task automatic wait_on(input int i, input logic v);
      int n;
      n = 0;
      while (obs[i] !== v && n < 400) begin
         @(posedge SYS_CLK);
         n++;
      end
      cmp_pin(obs[i], v);
      if (obs[i] !== v)
         wrap_up();
   endtask
   // Watches answers and checks them against the oldest note.
   always @(posedge SYS_CLK) begin
      if (PSEL && PENABLE && PREADY === 1'b1) begin
         nt = q.pop_front();
         cmp({PSLVERR, PRDATA} & nt.m, nt.e);
      end
   end
   initial begin
      r = $urandom(23118);
      repeat (12) @(posedge SYS_CLK);
      RSTN <= 1'b1;
      @(posedge SYS_CLK);
      cmp_pin(CORE_CLK_EN & REFCLK_REQUEST_OUT & HOST_WAKE_OUT & !TRANSPORT_IDLE, 1'b1);
      rd(8'h00, 32'h0, 32'hFFFFFFFF);
      rd(8'h04, 32'h100, 32'hFFFFFFFF);
      rd(8'h08, 32'h40, 32'hFFFFFFFF);
      rd(8'h18, 32'h0, 32'hFFFFFFFF);
      apb(1'b0, 8'h1C, 32'h0, {1'b1, 32'h0}, {33{1'b1}});
      r = $urandom;
      wr(8'h04, r);
      rd(8'h04, {16'h0, r[15:0]}, 32'hFFFFFFFF);
      wr(8'h08, ~r);
      rd(8'h08, {16'h0, ~r[15:0]}, 32'hFFFFFFFF);
      wr(8'h04, 32'h2);
      wr(8'h08, 32'h4);
      $display("done registers");
      for (int p = 0; p < 2; p++) begin
         wpol <= p[0];
         wr(8'h00, {30'h0, p[0], 1'b1});
         repeat (20) @(posedge SYS_CLK);
         cmp_pin(CORE_CLK_EN, 1'b1);
         need <= 1'b0;
         PKT_TX_ACTIVE <= 1'b1;
         wait_on(0, 1'b0);
         @(posedge SYS_CLK);
         cmp_pin(REFCLK_REQUEST_OUT | RF_TX_EN | RF_RX_EN | !TRANSPORT_IDLE, 1'b0);
         rd(8'h0C, 32'h1, 32'h3);
         rd(8'h10, 32'h4, 32'h4);
         need <= 1'b1;
         wait_on(0, 1'b1);
         rd(8'h10, 32'h1, 32'h1);
         cmp_pin(RF_TX_EN, 1'b1);
         wr(8'h18, 32'h1F);
      end
      $display("done sleep");
      need <= 1'b0;
      for (int p = 0; p < 2; p++) begin
         hpol <= p[0];
         wr(8'h00, {24'h0, 1'b1, 4'h0, p[0], 2'h2});
         wait_on(4, p[0]);
         wait_on(5, 1'b1);
         wr(8'h00, {29'h0, p[0], 2'h2});
         wait_on(4, !p[0]);
         wait_on(5, 1'b0);
      end
      $display("done host wake");
      wr(8'h00, 32'h23);
      wait_on(0, 1'b0);
      wait_on(0, 1'b1);
      cmp_pin(TRANSPORT_IDLE, 1'b1);
      wait_on(0, 1'b0);
      rd(8'h10, 32'h2, 32'h2);
      need <= 1'b1;
      wait_on(0, 1'b1);
      repeat (10) @(posedge SYS_CLK);
      k = 0;
      // Receive path must follow the packet level seen one edge earlier while awake.
      rx_q = PKT_RX_ACTIVE;
      repeat (200) begin
         @(posedge SYS_CLK);
         k += !CORE_CLK_EN | TRANSPORT_IDLE | (RF_RX_EN !== rx_q);
         rx_q = PKT_RX_ACTIVE;
      end
      cmp_pin(k == 0, 1'b1);
      wr(8'h00, 32'h43);
      need <= 1'b0;
      wait_on(0, 1'b0);
      wait_on(0, 1'b1);
      rd(8'h10, 32'h8, 32'h8);
      need <= 1'b1;
      wait_on(0, 1'b1);
      $display("done timers");
      wr(8'h00, 32'h1A);
      wait_on(1, 1'b1);
      @(posedge SYS_CLK);
      cmp_pin(RF_TX_EN, 1'b0);
      need <= 1'b0;
      wait_on(1, 1'b0);
      wr(8'h00, 32'h9A);
      USB_SUSPEND <= 1'b1;
      wait_on(2, 1'b1);
      cmp_pin(HOST_WAKE_OUT, 1'b1);
      USB_SUSPEND <= 1'b0;
      USB_RESUME <= 1'b1;
      repeat (4) @(posedge SYS_CLK);
      USB_RESUME <= 1'b0;
      wait_on(2, 1'b0);
      rd(8'h10, 32'h10, 32'h10);
      wr(8'h14, 32'h10);
      wait_on(3, 1'b1);
      wr(8'h14, 32'h0);
      wait_on(3, 1'b0);
      wr(8'h14, 32'h10);
      wait_on(3, 1'b1);
      wr(8'h18, 32'h10);
      wait_on(3, 1'b0);
      rd(8'h10, 32'h0, 32'h10);
      $display("done usb and interrupt");
      wrap_up();
   end
endmodule // tb
